// ===== rtl/pcm_slot_pkg.sv
// Package of register offsets, field positions and reset values.
package pcm_slot_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int          REG_AW          = 7;
  localparam int          REG_DW          = 9;
  localparam logic [6:0]  OFS_LEFT_LOW    = 7'h3B;
  localparam logic [6:0]  OFS_MISC        = 7'h3C;
  localparam logic [6:0]  OFS_RIGHT_LOW   = 7'h3D;
  localparam logic [6:0]  OFS_REVISION    = 7'h3E;
  localparam logic [6:0]  OFS_IDENTITY    = 7'h3F;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [8:0]  RST_SLOT_LOW    = 9'h000;
  localparam logic [8:0]  RST_MISC        = 9'h020;

  // ****************************************************************
  // Fields of the miscellaneous port register.
  // ****************************************************************
  localparam int          BIT_PLACE_EN    = 8;
  localparam int          BIT_TRISTATE    = 7;
  localparam int          BIT_SHORT_WORD  = 6;
  localparam int          BIT_DRIVER_EN   = 5;
  localparam int          BIT_PULL_EN     = 4;
  localparam int          BIT_PULL_SEL    = 3;
  localparam int          BIT_RIGHT_MSB   = 1;
  localparam int          BIT_LEFT_MSB    = 0;
  localparam logic [8:0]  MISC_WR_MASK    = 9'h1FB;

  // ****************************************************************
  // Link timing.
  // ****************************************************************
  localparam int          START_W         = 10;
  localparam logic [9:0]  SHORT_WORD_LEN  = 10'h008;

endpackage : pcm_slot_pkg

// ===== rtl/pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module pair_buffer #(
  parameter int W = 48
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem_r [2];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   count_r;
  logic         push;
  logic         pop;

  // Honest full and empty from the fill count.
  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule : pair_buffer

// ===== rtl/pcm_time_slot_control.sv
// PCM time-slot port: registers, slot timing and record data pin.
`timescale 1ns/100ps
module pcm_time_slot_control
  import pcm_slot_pkg::*;
#(
  parameter int         WORD_W      = 24,
  parameter logic [8:0] REVISION    = 9'h003, // Arbitrary value.
  parameter logic [8:0] BUS_ADDRESS = 9'h055  // Arbitrary value.
) (
  // System clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port.
  input  wire logic [REG_AW-1:0]   reg_addr,
  input  wire logic [REG_DW-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [REG_DW-1:0]        reg_rdata,
  // Audio format from the port format control.
  input  wire logic                pcm_format,
  // Record words from the converter.
  input  wire logic [WORD_W-1:0]   rec_left,
  input  wire logic [WORD_W-1:0]   rec_right,
  input  wire logic                rec_valid,
  output logic                     rec_ready,
  // Playback words to the converter.
  output logic [WORD_W-1:0]        play_left,
  output logic [WORD_W-1:0]        play_right,
  output logic                     play_valid,
  // Passive pull controls for the record data pin.
  output logic                     pull_up_en,
  output logic                     pull_down_en,
  // Link pins, all on the bit clock.
  input  wire logic                bclk,
  input  wire logic                frame_sync,
  input  wire logic                play_serial_in,
  output logic                     record_serial_out_o,
  output logic                     record_serial_out_oe
);

  localparam int FW = 2 * WORD_W;

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // Joins a misc MSB onto a 9-bit low field.
  function automatic logic [START_W-1:0] join_start(
    input logic       msb,
    input logic [8:0] low
  );
    join_start = {msb, low};
  endfunction : join_start

  // Word length in bit times for the word-size setting.
  function automatic logic [START_W-1:0] word_len(input logic short_w);
    word_len = short_w ? SHORT_WORD_LEN : START_W'(WORD_W);
  endfunction : word_len

  // ****************************************************************
  // Register file, system clock.
  // ****************************************************************
  logic [8:0] left_low_r;
  logic [8:0] right_low_r;
  logic [8:0] misc_r;

  // Register writes; read-only offsets take no write.
  always_ff @(posedge clk) begin
    if (rst) begin
      left_low_r  <= RST_SLOT_LOW;
      right_low_r <= RST_SLOT_LOW;
      misc_r      <= RST_MISC;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_LEFT_LOW:  left_low_r  <= reg_wdata;
        OFS_RIGHT_LOW: right_low_r <= reg_wdata;
        OFS_MISC:      misc_r      <= reg_wdata & MISC_WR_MASK;
        default:       left_low_r  <= left_low_r;
      endcase
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 9'h000;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_LEFT_LOW:  reg_rdata <= left_low_r;
        OFS_MISC:      reg_rdata <= misc_r;
        OFS_RIGHT_LOW: reg_rdata <= right_low_r;
        OFS_REVISION:  reg_rdata <= REVISION;
        OFS_IDENTITY:  reg_rdata <= BUS_ADDRESS;
        default:       reg_rdata <= 9'h000;
      endcase
    end
  end

  // Passive pull resistors on the record data pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      pull_up_en   <= 1'b0;
      pull_down_en <= 1'b0;
    end else begin
      pull_up_en   <= misc_r[BIT_PULL_EN] && misc_r[BIT_PULL_SEL];
      pull_down_en <= misc_r[BIT_PULL_EN] && !misc_r[BIT_PULL_SEL];
    end
  end

  // ****************************************************************
  // Record path, system side: buffer and request handshake.
  // ****************************************************************
  logic [FW-1:0] buf_data;
  logic          buf_valid;
  logic          buf_ready;
  logic [FW-1:0] hold_r;
  logic          req_r;
  logic          ack_s1_r;
  logic          ack_s2_r;
  logic          busy;

  // A stalled link stops acknowledging, which fills the buffer.
  pair_buffer #(
    .W (FW)
  ) u_rec_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rec_valid),
    .in_ready  (rec_ready),
    .in_data   ({rec_left, rec_right}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign busy      = (req_r != ack_s2_r);
  assign buf_ready = !busy;

  // Hold a frame word and toggle the request for the link side.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= '0;
      req_r  <= 1'b0;
    end else if (buf_valid && !busy) begin
      hold_r <= buf_data;
      req_r  <= ~req_r;
    end
  end

  // Acknowledge synchroniser from the link side.
  logic ack_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // ****************************************************************
  // Link clock domain: reset and configuration crossing.
  // ****************************************************************
  logic       lrst_s1_r;
  logic       lrst;
  logic [8:0] cfg_misc_s1_r;
  logic [8:0] cfg_misc_r;
  logic [8:0] cfg_left_s1_r;
  logic [8:0] cfg_left_r;
  logic [8:0] cfg_right_s1_r;
  logic [8:0] cfg_right_r;
  logic       cfg_pcm_s1_r;
  logic       cfg_pcm_r;
  logic       req_s1_r;
  logic       req_s2_r;

  // Reset crossing into the bit clock.
  always_ff @(posedge bclk) begin
    lrst_s1_r <= rst;
    lrst      <= lrst_s1_r;
  end

  // Quasi-static settings pass two flip-flops into the bit clock.
  always_ff @(posedge bclk) begin
    cfg_misc_s1_r  <= misc_r;
    cfg_misc_r     <= cfg_misc_s1_r;
    cfg_left_s1_r  <= left_low_r;
    cfg_left_r     <= cfg_left_s1_r;
    cfg_right_s1_r <= right_low_r;
    cfg_right_r    <= cfg_right_s1_r;
    cfg_pcm_s1_r   <= pcm_format;
    cfg_pcm_r      <= cfg_pcm_s1_r;
    req_s1_r       <= req_r;
    req_s2_r       <= req_s1_r;
  end

  // ****************************************************************
  // Link clock domain: slot timing.
  // ****************************************************************
  logic [START_W-1:0] cnt_r;
  logic [START_W-1:0] cur;
  logic [START_W-1:0] len;
  logic [START_W-1:0] ls;
  logic [START_W-1:0] rs;
  logic [START_W-1:0] loff;
  logic [START_W-1:0] roff;
  logic               place;
  logic               lact;
  logic               ract;

  // Bit-time index: zero at the edge that samples frame sync.
  assign cur   = frame_sync ? '0 : cnt_r;
  assign len   = word_len(cfg_misc_r[BIT_SHORT_WORD]);
  assign place = cfg_misc_r[BIT_PLACE_EN] && cfg_pcm_r;
  // Programmed starts, or left first and right straight after it.
  assign ls    = place ? join_start(cfg_misc_r[BIT_LEFT_MSB],
                                    cfg_left_r) : '0;
  assign rs    = place ? join_start(cfg_misc_r[BIT_RIGHT_MSB],
                                    cfg_right_r) : len;
  assign loff  = cur - ls;
  assign roff  = cur - rs;
  // Left wins if the host lets the slots overlap.
  assign lact  = (cur >= ls) && (loff < len);
  assign ract  = (cur >= rs) && (roff < len) && !lact;

  // Bit counter; holds at its top so a missing sync does not wrap.
  always_ff @(posedge bclk) begin
    if (lrst) begin
      cnt_r <= '0;
    end else if (cur != '1) begin
      cnt_r <= cur + START_W'(1);
    end
  end

  // ****************************************************************
  // Link clock domain: record shifting and pin drive.
  // ****************************************************************
  logic [FW-1:0]     frame_r;
  logic [FW-1:0]     frame_src;
  logic [WORD_W-1:0] tx_sh_r;
  logic              fetch;

  assign fetch = frame_sync && (req_s2_r != ack_r);
  // A slot that opens on the sync edge must already see the new pair.
  assign frame_src = fetch ? hold_r : frame_r;

  // Take a pending frame word at frame sync and acknowledge it.
  always_ff @(posedge bclk) begin
    if (lrst) begin
      frame_r <= '0;
      ack_r   <= 1'b0;
    end else if (fetch) begin
      frame_r <= hold_r;
      ack_r   <= ~ack_r;
    end
  end

  // Shift each word out MSB first during its slot.
  always_ff @(posedge bclk) begin
    if (lrst) begin
      tx_sh_r             <= '0;
      record_serial_out_o <= 1'b0;
    end else if (lact && loff == '0) begin
      record_serial_out_o <= frame_src[FW-1];
      tx_sh_r <= {frame_src[FW-2:WORD_W], 1'b0};
    end else if (ract && roff == '0) begin
      record_serial_out_o <= frame_src[WORD_W-1];
      tx_sh_r <= {frame_src[WORD_W-2:0], 1'b0};
    end else if (lact || ract) begin
      record_serial_out_o <= tx_sh_r[WORD_W-1];
      tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
    end
  end

  // Drive enable: off with the driver bit clear, and off after the
  // last bit of a slot when the tristate option is set.
  always_ff @(posedge bclk) begin
    if (lrst) begin
      record_serial_out_oe <= 1'b0;
    end else begin
      record_serial_out_oe <= cfg_misc_r[BIT_DRIVER_EN] &&
        (lact || ract || !cfg_misc_r[BIT_TRISTATE]);
    end
  end

  // ****************************************************************
  // Link clock domain: playback capture.
  // ****************************************************************
  logic [WORD_W-1:0] rx_sh_r;
  logic [WORD_W-1:0] rx_left_r;
  logic [WORD_W-1:0] rx_right_r;
  logic              rx_tog_r;
  logic [WORD_W-1:0] rx_next;

  assign rx_next = {rx_sh_r[WORD_W-2:0], play_serial_in};

  // Sample playback bits in each slot; a short word lands low.
  always_ff @(posedge bclk) begin
    if (lrst) begin
      rx_sh_r    <= '0;
      rx_left_r  <= '0;
      rx_right_r <= '0;
      rx_tog_r   <= 1'b0;
    end else if (lact || ract) begin
      rx_sh_r <= ((lact ? loff : roff) == '0) ?
                 {{(WORD_W-1){1'b0}}, play_serial_in} : rx_next;
      if (lact && loff == len - START_W'(1)) begin
        rx_left_r <= ((loff == '0) ? '0 : rx_next);
      end
      if (ract && roff == len - START_W'(1)) begin
        rx_right_r <= rx_next;
        rx_tog_r   <= ~rx_tog_r;
      end
    end
  end

  // ****************************************************************
  // Playback words back into the system clock.
  // ****************************************************************
  logic rx_tog_s1_r;
  logic rx_tog_s2_r;
  logic rx_tog_s3_r;

  // Event crossing by toggle; the data is stable for a frame.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_tog_s1_r <= 1'b0;
      rx_tog_s2_r <= 1'b0;
      rx_tog_s3_r <= 1'b0;
    end else begin
      rx_tog_s1_r <= rx_tog_r;
      rx_tog_s2_r <= rx_tog_s1_r;
      rx_tog_s3_r <= rx_tog_s2_r;
    end
  end

  // Capture the stereo pair and pulse valid for one cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      play_left  <= '0;
      play_right <= '0;
      play_valid <= 1'b0;
    end else begin
      play_valid <= (rx_tog_s2_r != rx_tog_s3_r);
      if (rx_tog_s2_r != rx_tog_s3_r) begin
        play_left  <= rx_left_r;
        play_right <= rx_right_r;
      end
    end
  end

endmodule : pcm_time_slot_control

// ===== dv/pcm_slot_props.sv
// Checker of register-port and pin-control relations of the slot block.
`timescale 1ns/100ps
module pcm_slot_props
  import pcm_slot_pkg::*;
#(
  parameter logic [8:0] REVISION    = 9'h003, // Arbitrary value.
  parameter logic [8:0] BUS_ADDRESS = 9'h055  // Arbitrary value.
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst,
  // Register port.
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [REG_DW-1:0] reg_rdata,
  // Pin controls.
  input wire logic              pull_up_en,
  input wire logic              pull_down_en,
  input wire logic              record_serial_out_oe
);
  logic [8:0] misc_r;
  logic [4:0] quiet_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Helper state.
  // ****************************************************************
  // Shadow of the misc register, as the host has written it.
  always_ff @(posedge clk) begin
    if (rst) begin
      misc_r <= RST_MISC;
    end else if (reg_wr && reg_addr == OFS_MISC) begin
      misc_r <= reg_wdata & MISC_WR_MASK;
    end
  end
  // Clocks since the last misc write or the driver being enabled, saturating.
  always_ff @(posedge clk) begin
    if (rst || misc_r[BIT_DRIVER_EN] || (reg_wr && reg_addr == OFS_MISC))
      quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // A write to the misc register.
  sequence s_misc_wr;
    reg_wr && reg_addr == OFS_MISC;
  endsequence

  a_pull_up_follow: assert property (
    s_misc_wr ##0 reg_wdata[BIT_PULL_EN] && reg_wdata[BIT_PULL_SEL]
    |-> ##2 pull_up_en)
    else $error("pull-up not applied");
  a_pull_down_follow: assert property (
    s_misc_wr ##0 reg_wdata[BIT_PULL_EN] && !reg_wdata[BIT_PULL_SEL]
    |-> ##2 pull_down_en)
    else $error("pull-down not applied");
  a_pull_off_follow: assert property (
    s_misc_wr ##0 !reg_wdata[BIT_PULL_EN]
    |-> ##2 !pull_up_en && !pull_down_en)
    else $error("pull applied while disabled");
  a_pulls_exclusive: assert property (!(pull_up_en && pull_down_en))
    else $error("both pulls applied");
  a_driver_off_quiet: assert property (
    quiet_r == 5'h1F |-> !record_serial_out_oe)
    else $error("record pin driven while driver disabled");
  a_revision_read: assert property (
    reg_rd && reg_addr == OFS_REVISION |=> reg_rdata == REVISION)
    else $error("wrong revision readback");
  a_identity_read: assert property (
    reg_rd && reg_addr == OFS_IDENTITY |=> reg_rdata == BUS_ADDRESS)
    else $error("wrong identity readback");
  a_misc_readback: assert property (
    reg_rd && reg_addr == OFS_MISC |=> reg_rdata == $past(misc_r))
    else $error("wrong misc readback");
endmodule : pcm_slot_props

bind pcm_time_slot_control pcm_slot_props #(
  .REVISION(REVISION),
  .BUS_ADDRESS(BUS_ADDRESS)
) chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
  .record_serial_out_oe(record_serial_out_oe)
);

// ===== dv/pcm_host_model.sv
// Host-side model of the PCM port: bit clock, frame sync and data lines.
`timescale 1ns/100ps
module pcm_host_model (
  // Link pins driven by the host.
  output logic      bclk,
  output logic      frame_sync,
  output logic      play_serial_in,
  // Record pin and its pull controls from the device.
  input  wire logic rso,
  input  wire logic rso_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en
);
  localparam int FRAME_LEN = 576;
  logic [FRAME_LEN-1:0] cap_bit;
  logic [FRAME_LEN-1:0] cap_oe;
  logic                 wire_lvl;

  // Pin level: device drive, else a pull, else a level that keeps moving.
  assign wire_lvl = rso_oe ? rso : pull_up_en ? 1'b1 :
                    pull_down_en ? 1'b0 : ~play_serial_in;

  // The bit clock runs free, since the device needs it during reset.
  initial begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    play_serial_in = 1'b0;
    forever #6 bclk = ~bclk;
  end

  // One frame: sync at edge 0, playback bits in the slots, record captured.
  task automatic run_frame(input int ls, input int rs, input int len,
                           input logic [47:0] ptx);
    @(negedge bclk);
    frame_sync = 1'b1;
    for (int k = 0; k <= FRAME_LEN; k++) begin
      if (k >= ls && k < ls + len) play_serial_in = ptx[47 - (k - ls)];
      else if (k >= rs && k < rs + len) play_serial_in = ptx[23 - (k - rs)];
      else play_serial_in = ~play_serial_in;
      @(posedge bclk);
      if (k > 0) begin
        cap_bit[k-1] = wire_lvl;
        cap_oe[k-1] = rso_oe;
      end
      @(negedge bclk);
      frame_sync = 1'b0;
    end
  endtask : run_frame
endmodule : pcm_host_model

// ===== dv/pcm_time_slot_control_test.sv
// Self-checking bench for the PCM time-slot control block.
`timescale 1ns/100ps
module pcm_time_slot_control_test
  import pcm_slot_pkg::*;
;
  localparam logic [8:0] REV_V = 9'h003; // Arbitrary value.
  localparam logic [8:0] ID_V  = 9'h055; // Arbitrary value.
  logic              clk, rst, reg_wr, reg_rd, pcm_format;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  logic [23:0]       rec_left, rec_right, play_left, play_right;
  logic              rec_valid, rec_ready, play_valid, pull_up_en;
  logic              pull_down_en, bclk, frame_sync, psi, rso, rso_oe;
  logic [47:0]       pv_pair;
  int                error_cnt, total_checks, cycles, pv_cnt;

  pcm_time_slot_control #(.REVISION(REV_V), .BUS_ADDRESS(ID_V)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pcm_format(pcm_format), .rec_left(rec_left), .rec_right(rec_right),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .play_left(play_left),
    .play_right(play_right), .play_valid(play_valid),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .bclk(bclk),
    .frame_sync(frame_sync), .play_serial_in(psi),
    .record_serial_out_o(rso), .record_serial_out_oe(rso_oe));
  pcm_host_model host (
    .bclk(bclk), .frame_sync(frame_sync), .play_serial_in(psi), .rso(rso),
    .rso_oe(rso_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

  // ****************************************************************
  // Clock, timeout and playback monitor.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  // Keeps the last playback pair and counts them.
  always @(posedge clk) begin
    if (play_valid === 1'b1) begin
      pv_pair <= {play_left, play_right};
      pv_cnt <= pv_cnt + 1;
    end
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask : rd_chk
  task automatic push(input logic [47:0] p);
    @(negedge clk);
    {rec_left, rec_right} = p;
    rec_valid = 1'b1;
    @(posedge clk);
    while (rec_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    rec_valid = 1'b0;
  endtask : push
  // Runs one frame and judges the record pin and the playback pair.
  task automatic frame(input int ls, input int rs, input int len,
                       input logic drv, input logic tri_en,
                       input logic [47:0] p);
    int  n0;
    logic act;
    n0 = pv_cnt;
    repeat (30) @(negedge clk);
    host.run_frame(ls, rs, len, p);
    repeat (30) @(negedge clk);
    for (int k = 0; k < 576; k++) begin
      act = (k >= ls && k < ls + len) || (k >= rs && k < rs + len);
      check(host.cap_oe[k], drv & (act | ~tri_en));
      if (drv && k >= ls && k < ls + len)
        check(host.cap_bit[k], p[47 - (k - ls)]);
      else if (drv && k >= rs && k < rs + len)
        check(host.cap_bit[k], p[23 - (k - rs)]);
    end
    check(pv_cnt > n0, 1'b1);
    if (len == 8) check(pv_pair, {16'h0, p[47:40], 16'h0, p[23:16]});
    else check(pv_pair, p);
  endtask : frame

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Reset values, read-only places, write mask and the pull controls.
  task automatic t_regs;
    rd_chk(OFS_LEFT_LOW, 9'h000);
    rd_chk(OFS_MISC, 9'h020);
    rd_chk(OFS_RIGHT_LOW, 9'h000);
    wr_reg(OFS_REVISION, ~REV_V);
    wr_reg(OFS_IDENTITY, ~ID_V);
    wr_reg(7'h10, 9'h1FF);
    rd_chk(OFS_REVISION, REV_V);
    rd_chk(OFS_IDENTITY, ID_V);
    rd_chk(7'h10, 9'h000);
    wr_reg(OFS_LEFT_LOW, 9'h1FF);
    wr_reg(OFS_RIGHT_LOW, 9'h155);
    wr_reg(OFS_MISC, 9'h1FF);
    rd_chk(OFS_LEFT_LOW, 9'h1FF);
    rd_chk(OFS_RIGHT_LOW, 9'h155);
    rd_chk(OFS_MISC, 9'h1FB);
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_MISC, 9'h020 | 9'(i < 2 ? 16 : 0) | 9'(i == 0 ? 8 : 0));
      repeat (3) @(negedge clk);
      check(pull_up_en, i == 0);
      check(pull_down_en, i == 1);
    end
  endtask : t_regs
  // Fills the buffer while the link stalls, then drains it frame by frame.
  task automatic t_buffer;
    logic [47:0] q [8];
    int          n;
    wr_reg(OFS_MISC, 9'h020);
    n = 0;
    while (rec_ready === 1'b1 && n < 6) begin
      q[n] = 48'h123456_654321 + 48'(n);
      push(q[n]);
      n++;
    end
    check(rec_ready, 1'b0);
    for (int j = 0; j < n; j++) frame(0, 24, 24, 1'b1, 1'b0, q[j]);
    check(rec_ready, 1'b1);
    frame(0, 24, 24, 1'b1, 1'b0, q[n-1]);
  endtask : t_buffer
  // Slot placement, tristate, short words and driver-off settings.
  task automatic t_slots;
    logic [8:0] mv [6] = '{9'h020, 9'h1A3, 9'h1A2, 9'h1E0, 9'h1A0, 9'h080};
    logic [8:0] ll [6] = '{9'h000, 9'h003, 9'h000, 9'h009, 9'h009, 9'h000};
    logic [8:0] rl [6] = '{9'h000, 9'h020, 9'h006, 9'h028, 9'h028, 9'h000};
    logic       fm [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [47:0] p;
    int          len, ls, rs;
    for (int i = 0; i < 6; i++) begin
      // Slots never overlap, fit the frame, and left comes first.
      wr_reg(OFS_LEFT_LOW, ll[i]);
      wr_reg(OFS_RIGHT_LOW, rl[i]);
      wr_reg(OFS_MISC, mv[i]);
      pcm_format = fm[i];
      len = mv[i][6] ? 8 : 24;
      ls = (mv[i][8] & fm[i]) ? int'({mv[i][0], ll[i]}) : 0;
      rs = (mv[i][8] & fm[i]) ? int'({mv[i][1], rl[i]}) : len;
      p = 48'hA5C3F0_3C5A0F ^ {8{6'(i)}};
      push(p);
      frame(ls, rs, len, mv[i][5], mv[i][7], p);
    end
  endtask : t_slots

  // Prints the verdict and ends the run.
  task automatic results;
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // Main sequence: reset long enough for both domains, then scenarios.
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
    pcm_format = 1'b1;
    rec_valid = 1'b0;
    rec_left = 24'h000000;
    rec_right = 24'h000000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    t_regs();
    t_buffer();
    t_slots();
    results();
  end
endmodule : pcm_time_slot_control_test
